/* File: core/aue_error_regs.sv */
// uncorrectable error status and mask registers of one switch port
`timescale 1ns/1ps
module aue_error_regs (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_reset_n,
  input  wire logic                  i_hot_reset,
  input  wire aue_pkg::aue_bus_req_t i_bus,
  input  wire aue_pkg::aue_err_evt_t i_err_evt,
  output logic [31:0]                o_rdata,
  output logic                       o_report_valid,
  output logic [6:0]                 o_report_vec,
  output logic                       o_fep_valid,
  output logic [4:0]                 o_first_error_ptr
);

  logic       rst_meta_n;
  logic       rst_n;
  logic [6:0] evt_vec;
  logic [6:0] flag_vec;
  logic [6:0] clr_vec;
  logic [6:0] evt_masked;
  logic [6:0] evt_live;
  logic [31:0] status_word;
  logic [31:0] mask_word;
  logic [6:0] mask_evt;
  logic       mask_legacy;
  logic       double_bit_report_enable;
  logic       wr_status;
  logic       wr_mask;
  logic       wr_ctl;
  logic [4:0] next_fep;
  logic       fep_hit;
  logic [31:0] next_rdata;

  // field position of each event index
  function automatic int unsigned evt_pos(input int unsigned idx);
    case (idx)
      aue_pkg::EVT_LINK_PROTO:  evt_pos = aue_pkg::LINK_PROTO_POS;
      aue_pkg::EVT_UNEXP_CPL:   evt_pos = aue_pkg::UNEXP_CPL_POS;
      aue_pkg::EVT_RX_OVERFLOW: evt_pos = aue_pkg::RX_OVERFLOW_POS;
      aue_pkg::EVT_MALFORMED:   evt_pos = aue_pkg::MALFORMED_POS;
      aue_pkg::EVT_ECRC:        evt_pos = aue_pkg::ECRC_POS;
      aue_pkg::EVT_UNSUP_REQ:   evt_pos = aue_pkg::UNSUP_REQ_POS;
      default:                  evt_pos = aue_pkg::DOUBLE_BIT_POS;
    endcase
  endfunction

  // power-on reset released through two flops
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_n <= 1'h0;
      rst_n      <= 1'h0;
    end else begin
      rst_meta_n <= 1'h1;
      rst_n      <= rst_meta_n;
    end
  end

  assign evt_vec = i_err_evt;
  assign wr_status = i_bus.wr && (i_bus.addr == aue_pkg::STATUS_OFFSET);
  assign wr_mask = i_bus.wr && (i_bus.addr == aue_pkg::MASK_OFFSET);
  assign wr_ctl = i_bus.wr && (i_bus.addr == aue_pkg::MEM_ERR_CTL_OFFSET);

  // memory error control is not sticky: hot reset returns it to default
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      double_bit_report_enable <= aue_pkg::MEM_ERR_CTL_RESET;
    end else if (i_hot_reset) begin
      double_bit_report_enable <= aue_pkg::MEM_ERR_CTL_RESET;
    end else if (wr_ctl) begin
      double_bit_report_enable <= i_bus.wdata[aue_pkg::DBL_REPORT_EN_POS];
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_evt    <= 7'h00;
      mask_legacy <= 1'h0;
    end else if (wr_mask) begin
      mask_legacy <= i_bus.wdata[aue_pkg::UNUSED_LEGACY_POS];
      for (int i = 0; i < 7; i++) begin
        mask_evt[i] <= i_bus.wdata[evt_pos(i)];
      end
    end
  end

  // status flags, one sticky cell each
  genvar g;
  generate
    for (g = 0; g < 7; g++) begin : g_flag
      assign clr_vec[g] = wr_status && i_bus.wdata[evt_pos(g)];
      aue_sticky_bit u_flag (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (rst_n),
        .i_enable  ((g == aue_pkg::EVT_DOUBLE_BIT) ?
                    double_bit_report_enable : 1'b1),
        .i_set     (evt_vec[g]),
        .i_clear   (clr_vec[g]),
        .o_flag    (flag_vec[g])
      );
    end
  endgenerate

  always_comb begin
    status_word = aue_pkg::STATUS_RESET;
    mask_word   = aue_pkg::MASK_RESET;
    mask_word[aue_pkg::UNUSED_LEGACY_POS] = mask_legacy;
    for (int i = 0; i < 7; i++) begin
      status_word[evt_pos(i)] = flag_vec[i];
      if (i != aue_pkg::EVT_DOUBLE_BIT) begin
        mask_word[evt_pos(i)] = mask_evt[i];
      end
    end
  end

  // masking gates reporting and pointer, never the flags
  assign evt_live = {double_bit_report_enable, 6'h3f} & evt_vec;
  assign evt_masked = evt_live & ~{1'b0, mask_evt[5:0]};

  // lowest-numbered unmasked event becomes the first error
  always_comb begin
    next_fep = o_first_error_ptr;
    for (int i = 6; i >= 0; i--) begin
      if (evt_masked[i]) begin
        next_fep = 5'(evt_pos(i));
      end
    end
  end

  assign fep_hit = o_fep_valid && status_word[o_first_error_ptr];

  // first error pointer, sticky like the flags
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_fep_valid       <= 1'h0;
      o_first_error_ptr <= aue_pkg::FEP_RESET;
    end else if (!fep_hit && (evt_masked != 7'h00)) begin
      o_fep_valid       <= 1'h1;
      o_first_error_ptr <= next_fep;
    end else if (!fep_hit) begin
      o_fep_valid <= 1'h0;
    end
  end

  // error messages toward the root complex
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_report_valid <= 1'h0;
      o_report_vec   <= 7'h00;
    end else if (i_hot_reset) begin
      o_report_valid <= 1'h0;
      o_report_vec   <= 7'h00;
    end else begin
      o_report_valid <= (evt_masked != 7'h00);
      o_report_vec   <= evt_masked;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (i_bus.rd) begin
      case (i_bus.addr)
        aue_pkg::STATUS_OFFSET: next_rdata = status_word;
        aue_pkg::MASK_OFFSET:   next_rdata = mask_word;
        aue_pkg::MEM_ERR_CTL_OFFSET: begin
          next_rdata[aue_pkg::DBL_REPORT_EN_POS] = double_bit_report_enable;
        end
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!rst_n);

  property p_cpl_timeout_zero;
    i_bus.rd && i_bus.addr == aue_pkg::STATUS_OFFSET
      |=> o_rdata[aue_pkg::CPL_TIMEOUT_POS] == 1'b0;
  endproperty
  a_cpl_timeout_zero: assert property (p_cpl_timeout_zero)
    else $error("completion timeout status not zero");

  property p_cpl_abort_read;
    i_bus.rd && i_bus.addr == aue_pkg::STATUS_OFFSET
      |=> o_rdata[aue_pkg::CPL_ABORT_POS] == 1'b0;
  endproperty
  a_cpl_abort_read: assert property (p_cpl_abort_read)
    else $error("completer abort status read nonzero");

  property p_unexp_cpl_set;
    i_err_evt.unexp_cpl |=> status_word[aue_pkg::UNEXP_CPL_POS];
  endproperty
  a_unexp_cpl_set: assert property (p_unexp_cpl_set)
    else $error("unexpected completion not logged");

  property p_unexp_cpl_hold;
    status_word[aue_pkg::UNEXP_CPL_POS] && !clr_vec[aue_pkg::EVT_UNEXP_CPL]
      |=> status_word[aue_pkg::UNEXP_CPL_POS];
  endproperty
  a_unexp_cpl_hold: assert property (p_unexp_cpl_hold)
    else $error("unexpected completion flag lost");

  property p_rx_overflow_set;
    i_err_evt.rx_overflow && clr_vec[aue_pkg::EVT_RX_OVERFLOW]
      |=> status_word[aue_pkg::RX_OVERFLOW_POS];
  endproperty
  a_rx_overflow_set: assert property (p_rx_overflow_set)
    else $error("receiver overflow lost against clear");

  property p_malformed_set;
    i_err_evt.malformed |=> status_word[aue_pkg::MALFORMED_POS];
  endproperty
  a_malformed_set: assert property (p_malformed_set)
    else $error("malformed packet not logged");

  property p_ecrc_set;
    i_err_evt.ecrc |=> status_word[aue_pkg::ECRC_POS];
  endproperty
  a_ecrc_set: assert property (p_ecrc_set)
    else $error("ecrc error not logged");

  property p_unsup_clear;
    !i_err_evt.unsup_req && clr_vec[aue_pkg::EVT_UNSUP_REQ]
      |=> !status_word[aue_pkg::UNSUP_REQ_POS];
  endproperty
  a_unsup_clear: assert property (p_unsup_clear)
    else $error("unsupported request flag not cleared");

  property p_acs_zero;
    i_bus.rd && i_bus.addr == aue_pkg::STATUS_OFFSET
      |=> o_rdata[aue_pkg::ACS_VIOL_POS] == 1'b0;
  endproperty
  a_acs_zero: assert property (p_acs_zero)
    else $error("access control violation status nonzero");

  property p_dbl_set;
    double_bit_report_enable && !wr_ctl && i_err_evt.double_bit
      |=> status_word[aue_pkg::DOUBLE_BIT_POS];
  endproperty
  a_dbl_set: assert property (p_dbl_set)
    else $error("double-bit error not logged while enabled");

  property p_dbl_off;
    !double_bit_report_enable |=> !status_word[aue_pkg::DOUBLE_BIT_POS];
  endproperty
  a_dbl_off: assert property (p_dbl_off)
    else $error("double-bit status set while disabled");

  property p_masked_quiet;
    mask_evt[aue_pkg::EVT_UNEXP_CPL] && !wr_mask
      |=> !o_report_vec[aue_pkg::EVT_UNEXP_CPL];
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("masked error was reported");

  property p_mask_keeps_flag;
    mask_evt[aue_pkg::EVT_LINK_PROTO] && i_err_evt.link_proto
      |=> status_word[aue_pkg::LINK_PROTO_POS] &&
          !o_report_vec[aue_pkg::EVT_LINK_PROTO];
  endproperty
  a_mask_keeps_flag: assert property (p_mask_keeps_flag)
    else $error("masked link error lost or reported");

  property p_mask4_store;
    wr_mask |=> mask_word[aue_pkg::LINK_PROTO_POS] ==
      $past(i_bus.wdata[aue_pkg::LINK_PROTO_POS]);
  endproperty
  a_mask4_store: assert property (p_mask4_store)
    else $error("link error mask not stored");

  property p_mask0_store;
    wr_mask ##1 !wr_mask |-> mask_word[aue_pkg::UNUSED_LEGACY_POS] ==
      $past(i_bus.wdata[aue_pkg::UNUSED_LEGACY_POS], 1);
  endproperty
  a_mask0_store: assert property (p_mask0_store)
    else $error("legacy mask bit not stored");

  property p_link_set;
    i_err_evt.link_proto |=> status_word[aue_pkg::LINK_PROTO_POS];
  endproperty
  a_link_set: assert property (p_link_set)
    else $error("link protocol error not logged");

  property p_reserved_zero;
    i_bus.rd |=> o_rdata[30:22] == 9'h000 &&
      ($past(i_bus.addr) != aue_pkg::MASK_OFFSET || o_rdata[3:1] == 3'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read nonzero");

  property p_hot_keeps;
    i_hot_reset && !wr_status && !wr_mask
      |=> ((flag_vec[5:0] | ~$past(flag_vec[5:0])) == 6'h3f) &&
          $stable(mask_word);
  endproperty
  a_hot_keeps: assert property (p_hot_keeps)
    else $error("hot reset disturbed sticky bits");

  c_masked_event: cover property (mask_evt[0] && i_err_evt.link_proto);
  c_set_vs_clear: cover property (i_err_evt.ecrc && clr_vec[4]);
  c_dbl_logged: cover property (double_bit_report_enable &&
                                i_err_evt.double_bit);
  c_hot_reset_hold: cover property (i_hot_reset && (|flag_vec));

endmodule // aue_error_regs

/* File: core/aue_sticky_bit.sv */
// one sticky write-one-to-clear status flag
`timescale 1ns/1ps
module aue_sticky_bit (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_enable,
  input  wire logic i_set,
  input  wire logic i_clear,
  output logic      o_flag
);

  // power-on reset only; a hot reset clears the flag only by dropping i_enable
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_flag <= 1'h0;
    end else if (!i_enable) begin
      o_flag <= 1'h0;
    end else if (i_set) begin
      // set wins over a simultaneous clear
      o_flag <= 1'h1;
    end else if (i_clear) begin
      o_flag <= 1'h0;
    end
  end

endmodule // aue_sticky_bit

/* File: shared/aue_pkg.sv */
// shared constants and carriers for the uncorrectable error register bank
package aue_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_EVT = 7;
  localparam int unsigned PTR_W = 5;

  // register byte offsets
  localparam logic [11:0] STATUS_OFFSET = 12'h104;
  localparam logic [11:0] MASK_OFFSET = 12'h108;
  localparam logic [11:0] MEM_ERR_CTL_OFFSET = 12'h10c;

  // status and mask field positions
  localparam int unsigned UNUSED_LEGACY_POS = 0;
  localparam int unsigned LINK_PROTO_POS = 4;
  localparam int unsigned CPL_TIMEOUT_POS = 14;
  localparam int unsigned CPL_ABORT_POS = 15;
  localparam int unsigned UNEXP_CPL_POS = 16;
  localparam int unsigned RX_OVERFLOW_POS = 17;
  localparam int unsigned MALFORMED_POS = 18;
  localparam int unsigned ECRC_POS = 19;
  localparam int unsigned UNSUP_REQ_POS = 20;
  localparam int unsigned ACS_VIOL_POS = 21;
  localparam int unsigned DOUBLE_BIT_POS = 31;
  // double-bit reporting enable inside memory error control
  localparam int unsigned DBL_REPORT_EN_POS = 0;

  // event vector index of each detector
  localparam int unsigned EVT_LINK_PROTO = 0;
  localparam int unsigned EVT_UNEXP_CPL = 1;
  localparam int unsigned EVT_RX_OVERFLOW = 2;
  localparam int unsigned EVT_MALFORMED = 3;
  localparam int unsigned EVT_ECRC = 4;
  localparam int unsigned EVT_UNSUP_REQ = 5;
  localparam int unsigned EVT_DOUBLE_BIT = 6;

  // reset values
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic MEM_ERR_CTL_RESET = 1'h0;
  localparam logic [4:0] FEP_RESET = 5'h00;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } aue_bus_req_t;

  // one-cycle detector pulses
  typedef struct packed {
    logic double_bit;
    logic unsup_req;
    logic ecrc;
    logic malformed;
    logic rx_overflow;
    logic unexp_cpl;
    logic link_proto;
  } aue_err_evt_t;

endpackage

/* File: test/aue_error_regs_tb_top.sv */
// self-checking bench for the uncorrectable error register bank
`timescale 1ns/1ps
module aue_error_regs_tb_top;
  localparam logic [31:0] MASK_RW = 32'h001f_0011;
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  hot = 1'b0;
  aue_pkg::aue_bus_req_t bus = '0;
  aue_pkg::aue_err_evt_t evt = '0;
  logic [31:0]           rdata;
  logic                  rep_valid;
  logic [6:0]            rep_vec;
  logic                  fep_valid;
  logic [4:0]            fep_ptr;
  logic [15:0]           rc_cnt;
  int                    error_cnt = 0;
  int                    cmp_count = 0;
  integer                seed = 53;
  int                    exp_rep = 0;
  logic [31:0]           exp_st = '0;
  logic [31:0]           exp_mask = '0;
  logic                  exp_en = 1'b0;
  logic [31:0]           got;
  logic [31:0]           r;

  always #2 clk = ~clk;

  aue_error_regs i_aue_error_regs (
    .i_sys_clk         (clk),
    .i_reset_n         (rst_n),
    .i_hot_reset       (hot),
    .i_bus             (bus),
    .i_err_evt         (evt),
    .o_rdata           (rdata),
    .o_report_valid    (rep_valid),
    .o_report_vec      (rep_vec),
    .o_fep_valid       (fep_valid),
    .o_first_error_ptr (fep_ptr)
  );

  aue_root_model i_aue_root_model (
    .i_sys_clk      (clk),
    .i_reset_n      (rst_n),
    .i_report_valid (rep_valid),
    .i_report_vec   (rep_vec),
    .o_report_cnt   (rc_cnt)
  );

  task automatic stop_test;
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string what);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, g, e);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask

  function automatic logic [31:0] to_st(input logic [6:0] e);
    logic [31:0] s;
    s = '0;
    s[4] = e[0];
    s[20:16] = e[5:1];
    s[31] = e[6];
    return s;
  endfunction

  // double-bit errors are dropped entirely while reporting is off
  function automatic logic [6:0] live(input logic [6:0] e);
    return e & {exp_en, 6'h3f};
  endfunction

  // c, when nonzero, is a write-one-to-clear landing with the events
  task automatic pulse(input logic [6:0] e, input logic [31:0] c);
    logic [6:0] u;
    u = live(e) & ~{1'b0, exp_mask[20:16], exp_mask[4]};
    @(posedge clk);
    evt <= e;
    if (|c)
      bus <= '{addr: aue_pkg::STATUS_OFFSET, wdata: c, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    evt <= '0;
    bus.wr <= 1'b0;
    #1;
    chk({31'h0, rep_valid}, {31'h0, |u}, "report flag");
    chk({25'h0, rep_vec}, {25'h0, u}, "report vector");
    if (|u)
      exp_rep++;
    // set wins over a clear in the same cycle
    exp_st &= ~c;
    exp_st |= to_st(live(e));
  endtask

  task automatic chk_st;
    rd(aue_pkg::STATUS_OFFSET, got);
    chk(got, exp_st, "status");
  endtask

  task automatic set_mask(input logic [31:0] m);
    wr(aue_pkg::MASK_OFFSET, m);
    exp_mask = m & MASK_RW;
  endtask

  task automatic set_en(input logic en);
    wr(aue_pkg::MEM_ERR_CTL_OFFSET, {31'h0, en});
    exp_en = en;
    if (!en)
      exp_st[31] = 1'b0;
  endtask

  task automatic por;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  initial begin
    got = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk_st();
    rd(aue_pkg::MASK_OFFSET, got);
    chk(got, aue_pkg::MASK_RESET, "mask reset");
    wr(aue_pkg::STATUS_OFFSET, 32'hffff_ffff);
    chk_st();
    set_mask(32'hffff_ffff);
    rd(aue_pkg::MASK_OFFSET, got);
    chk(got, MASK_RW, "mask bits");
    set_mask(32'h0000_0000);
    pulse(7'h10, 32'h0);
    chk({26'h0, fep_valid, fep_ptr}, 32'h0000_0033, "pointer");
    set_mask(32'h0001_0010);
    pulse(7'h03, 32'h0);
    chk({26'h0, fep_valid, fep_ptr}, 32'h0000_0033, "held ptr");
    chk_st();
    pulse(7'h40, 32'h0);
    chk_st();
    // events landing on a clear of every flag: the events must win
    pulse(7'h14, 32'hffff_ffff);
    chk_st();
    for (int i = 0; i < 160; i++) begin
      r = $random(seed);
      case (r[2:0])
        3'h0: set_mask(r);
        3'h1: set_en(r[8]);
        3'h2: begin
          wr(aue_pkg::STATUS_OFFSET, r);
          exp_st &= ~r;
        end
        default: begin
          // bit 3 lets some events meet a random clear
          pulse(r[14:8] & r[22:16], r[3] ? r : 32'h0);
        end
      endcase
      chk_st();
    end
    // hot reset must leave sticky state alone, except the double-bit flag, which drops with its enable
    set_en(1'b1);
    pulse(7'h7f, 32'h0);
    @(posedge clk);
    hot <= 1'b1;
    @(posedge clk);
    hot <= 1'b0;
    exp_en = 1'b0;
    exp_st[31] = 1'b0;
    rd(aue_pkg::MEM_ERR_CTL_OFFSET, got);
    chk(got, 32'h0000_0000, "enable after hot reset");
    chk_st();
    rd(aue_pkg::MASK_OFFSET, got);
    chk(got, exp_mask, "mask after hot reset");
    rd(12'h200, got);
    chk(got, 32'h0000_0000, "unmapped");
    chk({16'h0, rc_cnt}, exp_rep, "reports seen");
    por();
    exp_st = '0;
    chk_st();
    rd(aue_pkg::MASK_OFFSET, got);
    chk(got, 32'h0000_0000, "mask after power-on");
    stop_test();
  end

  // roughly seven times the expected run length
  initial begin
    #20000;
    error_cnt++;
    stop_test();
  end
endmodule // aue_error_regs_tb_top

/* File: test/aue_root_model.sv */
// root complex stand-in that counts incoming error reports
`timescale 1ns/1ps
module aue_root_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_report_valid,
  input  wire logic [6:0] i_report_vec,
  output logic [15:0]     o_report_cnt
);
  // an empty report carries no error, so it is not counted
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_report_cnt <= 16'h0000;
    end else if (i_report_valid && |i_report_vec) begin
      o_report_cnt <= o_report_cnt + 16'h0001;
    end
  end
endmodule // aue_root_model
